// File: design/ckv_pkg.sv
/*
  Package for the carkit event and vendor register bank: register
  addresses, field positions, reset values and conversion timing.
  Assumes a 40 MHz system clock and 6-bit register addresses.
*/
package ckv_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned CLK_FREQ_HZ = 40000000;
  localparam int unsigned MEASURE_TIME_US = 282;
  // Conversion time in cycles: 282 us times 40 cycles per us, exact with no rounding
  localparam int unsigned MEASURE_CYCLES = (MEASURE_TIME_US * (CLK_FREQ_HZ / 1000000));

  localparam logic [5:0] ADDR_CK_IRQ_EN_WR = 6'h1d;
  localparam logic [5:0] ADDR_CK_IRQ_EN_SET = 6'h1e;
  localparam logic [5:0] ADDR_CK_IRQ_EN_CLR = 6'h1f;
  localparam logic [5:0] ADDR_EVENT_STATUS = 6'h20;
  localparam logic [5:0] ADDR_EVENT_LATCH = 6'h21;
  localparam logic [5:0] ADDR_DRIVE_AMPL = 6'h31;
  localparam logic [5:0] ADDR_HEADSET_AUDIO = 6'h33;
  localparam logic [5:0] ADDR_ID_MEASURE_WR = 6'h36;
  localparam logic [5:0] ADDR_ID_MEASURE_SET = 6'h37;
  localparam logic [5:0] ADDR_ID_MEASURE_CLR = 6'h38;

  localparam int unsigned ST_OPEN_ID_BIT = 0;
  localparam int unsigned ST_CODE_LSB = 3;
  localparam int unsigned ST_DONE_BIT = 6;
  localparam int unsigned LT_OPEN_ID_BIT = 0;
  localparam int unsigned LT_MEASURE_BIT = 3;
  localparam int unsigned IE_RISE_BIT = 0;
  localparam int unsigned IE_FALL_BIT = 1;
  localparam int unsigned IE_MEASURE_BIT = 5;
  localparam int unsigned VM_CODE_LSB = 0;
  localparam int unsigned VM_DONE_BIT = 3;
  localparam int unsigned VM_START_BIT = 4;
  localparam int unsigned VM_RSVD_BIT = 5;
  localparam int unsigned VM_IRQ_EN_BIT = 6;
  localparam int unsigned BOOST_LSB = 5;

  localparam logic [3:0] HEADSET_KEY = 4'ha;
  localparam logic [1:0] BOOST_RESET = 2'h0;
  localparam logic [3:0] HEADSET_RESET = 4'h0;
  localparam logic [2:0] CODE_RESET = 3'h0;

endpackage

// File: design/ckv_if.sv
/*
  Interface between the register bank and its measurement timer.
  Assumes one clock domain shared by both sides.
*/
interface ckv_meas_if;
  timeunit 1ns;
  timeprecision 1ps;
  logic start;
  logic done;
  modport ctrl (output start, input done);
  modport timer (input start, output done);
endinterface

// File: design/ckv_meas_timer.sv
/*
  Conversion timer: counts the fixed conversion time after a start
  pulse and then gives a one-cycle done pulse.
  Assumes start is a single-cycle pulse from the register bank.
*/
module ckv_meas_timer
  import ckv_pkg::*;
#(
  parameter int unsigned CYCLES = MEASURE_CYCLES
) (
  input wire logic clk_i,          // System clock
  input wire logic sys_rst_i,      // Synchronous reset, high
  ckv_meas_if.timer meas           // Start and done handshake
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;

  always_comb begin
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (meas.start && !busy_reg) begin
      busy_next = 1'b1;
      cnt_next = 16'(CYCLES - 1);
    end else if (busy_reg) begin
      if (cnt_reg == 16'h0000) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= 16'h0000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign meas.done = done_reg;
endmodule

// File: design/ckv_regs.sv
/*
  Carkit event status and latch registers plus the vendor drive boost,
  headset audio and ID measurement registers behind the PHY register port.
  Assumes the ULPI front end decodes immediate and extended commands to a
  6-bit address with one-cycle read and write strobes; id_float_i is
  already synchronous and qualified by the ID pull-up.
*/
// Summary of operation
// - Status bit 0 shows ID pin floating
// - Unimplemented detect bits always read zero
// - Status bits 5:3 carry the resistor code
// - Done flag set after 282 us conversion
// - Done clears only on ID measurement register read
// - Status register read leaves done flag alone
// - Float latch set on enabled rise or fall
// - Measure latch set on enabled done rising
// - Latch register read clears latched bits
// - Immediate and extended addresses reach same registers
// - Vendor range 30h-3Fh reachable by immediate access
// - Boost field 6:5 selects drive amplitude
// - Headset audio only on exact key 1010
// - Start bit launches conversion, self-clears on completion
// - Measure irq enable is OR of two bits
// - Enabled carkit events raise alternate interrupt
module ckv_regs
  import ckv_pkg::*;
#(
  parameter int unsigned MEAS_CYCLES = MEASURE_CYCLES
) (
  input wire logic clk_i,             // 40 MHz system clock
  input wire logic sys_rst_i,         // Synchronous reset, high
  input wire logic [5:0] reg_addr_i,  // Register address, immediate or extended
  input wire logic reg_wr_i,          // Write strobe, one cycle
  input wire logic reg_rd_i,          // Read strobe, one cycle
  input wire logic [7:0] reg_wdata_i, // Write data
  input wire logic id_float_i,        // ID pin floating, pull-up enabled
  input wire logic [2:0] id_code_i,   // Resistor code from converter
  output logic [7:0] reg_rdata_o,     // Read data, valid cycle after read
  output logic [1:0] hs_boost_o,      // Drive amplitude select
  output logic headset_audio_en_o,    // Headset audio mode enabled
  output logic alt_int_o              // Alternate interrupt level to link
);
  timeunit 1ns;
  timeprecision 1ps;

  ckv_meas_if meas_if ();

  ckv_meas_timer #(
    .CYCLES(MEAS_CYCLES)
  ) u_timer (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .meas(meas_if.timer)
  );

  logic rise_en_reg, rise_en_next;
  logic fall_en_reg, fall_en_next;
  logic ck_meas_ie_reg, ck_meas_ie_next;
  logic vm_meas_ie_reg, vm_meas_ie_next;
  logic vm_rsvd_reg, vm_rsvd_next;
  logic start_reg, start_next;
  logic start_pulse_reg, start_pulse_next;
  logic done_reg, done_next;
  logic [2:0] code_reg, code_next;
  logic float_q_reg, float_q_next;
  logic open_ev_reg, open_ev_next;
  logic meas_ev_reg, meas_ev_next;
  logic [1:0] boost_reg, boost_next;
  logic [3:0] key_reg, key_next;
  logic [7:0] rdata_reg, rdata_next;
  logic audio_reg, audio_next;
  logic alt_reg, alt_next;

  logic meas_ie;
  logic [7:0] ie_val, vm_val, st_val, lt_val, rd_mux;
  logic wr_ie, set_ie, clr_ie, wr_vm, set_vm, clr_vm;
  logic [7:0] ie_new, vm_new;

  // Start is requested only on the rising edge of the start bit
  assign meas_if.start = start_pulse_reg;

  always_comb begin
    meas_ie = ck_meas_ie_reg | vm_meas_ie_reg;
    ie_val = 8'h00;
    ie_val[IE_RISE_BIT] = rise_en_reg;
    ie_val[IE_FALL_BIT] = fall_en_reg;
    ie_val[IE_MEASURE_BIT] = ck_meas_ie_reg;
    vm_val = 8'h00;
    vm_val[VM_CODE_LSB +: 3] = code_reg;
    vm_val[VM_DONE_BIT] = done_reg;
    vm_val[VM_START_BIT] = start_reg;
    vm_val[VM_RSVD_BIT] = vm_rsvd_reg;
    vm_val[VM_IRQ_EN_BIT] = vm_meas_ie_reg;
    // Bits 1 and 2 stay zero: car detect logic is not built
    st_val = 8'h00;
    st_val[ST_OPEN_ID_BIT] = id_float_i;
    st_val[ST_CODE_LSB +: 3] = code_reg;
    st_val[ST_DONE_BIT] = done_reg;
    lt_val = 8'h00;
    lt_val[LT_OPEN_ID_BIT] = open_ev_reg;
    lt_val[LT_MEASURE_BIT] = meas_ev_reg;
  end

  // One address decode serves both access forms
  always_comb begin
    wr_ie = reg_wr_i && reg_addr_i == ADDR_CK_IRQ_EN_WR;
    set_ie = reg_wr_i && reg_addr_i == ADDR_CK_IRQ_EN_SET;
    clr_ie = reg_wr_i && reg_addr_i == ADDR_CK_IRQ_EN_CLR;
    wr_vm = reg_wr_i && reg_addr_i == ADDR_ID_MEASURE_WR;
    set_vm = reg_wr_i && reg_addr_i == ADDR_ID_MEASURE_SET;
    clr_vm = reg_wr_i && reg_addr_i == ADDR_ID_MEASURE_CLR;
    ie_new = wr_ie ? reg_wdata_i : set_ie ? (ie_val | reg_wdata_i) :
             clr_ie ? (ie_val & ~reg_wdata_i) : ie_val;
    vm_new = wr_vm ? reg_wdata_i : set_vm ? (vm_val | reg_wdata_i) :
             clr_vm ? (vm_val & ~reg_wdata_i) : vm_val;
  end

  always_comb begin
    unique case (reg_addr_i)
      ADDR_CK_IRQ_EN_WR, ADDR_CK_IRQ_EN_SET, ADDR_CK_IRQ_EN_CLR: rd_mux = ie_val;
      ADDR_EVENT_STATUS: rd_mux = st_val;
      ADDR_EVENT_LATCH: rd_mux = lt_val;
      ADDR_DRIVE_AMPL: rd_mux = {1'b0, boost_reg, 5'h00};
      ADDR_HEADSET_AUDIO: rd_mux = {4'h0, key_reg};
      ADDR_ID_MEASURE_WR, ADDR_ID_MEASURE_SET, ADDR_ID_MEASURE_CLR: rd_mux = vm_val;
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    rise_en_next = ie_new[IE_RISE_BIT];
    fall_en_next = ie_new[IE_FALL_BIT];
    ck_meas_ie_next = ie_new[IE_MEASURE_BIT];
    vm_meas_ie_next = vm_new[VM_IRQ_EN_BIT];
    vm_rsvd_next = vm_new[VM_RSVD_BIT];
    code_next = code_reg;
    if (wr_vm) begin
      code_next = reg_wdata_i[VM_CODE_LSB +: 3];
    end
    start_next = vm_new[VM_START_BIT];
    start_pulse_next = vm_new[VM_START_BIT] && !start_reg;
    done_next = done_reg;
    // Reading the status register has no side effect on done
    if (reg_rd_i && (reg_addr_i == ADDR_ID_MEASURE_WR ||
        reg_addr_i == ADDR_ID_MEASURE_SET || reg_addr_i == ADDR_ID_MEASURE_CLR)) begin
      done_next = 1'b0;
    end
    if (meas_if.done) begin
      code_next = id_code_i;
      done_next = 1'b1;
      start_next = 1'b0;
    end
    float_q_next = id_float_i;
    open_ev_next = open_ev_reg;
    meas_ev_next = meas_ev_reg;
    if (reg_rd_i && reg_addr_i == ADDR_EVENT_LATCH) begin
      open_ev_next = 1'b0;
      meas_ev_next = 1'b0;
    end
    // Sets come after the clear so a coinciding event survives
    if ((id_float_i && !float_q_reg && rise_en_reg) ||
        (!id_float_i && float_q_reg && fall_en_reg)) begin
      open_ev_next = 1'b1;
    end
    if (meas_if.done && !done_reg && meas_ie) begin
      meas_ev_next = 1'b1;
    end
    boost_next = boost_reg;
    key_next = key_reg;
    if (reg_wr_i && reg_addr_i == ADDR_DRIVE_AMPL) begin
      boost_next = reg_wdata_i[BOOST_LSB +: 2];
    end
    if (reg_wr_i && reg_addr_i == ADDR_HEADSET_AUDIO) begin
      key_next = reg_wdata_i[3:0];
    end
    audio_next = key_next == HEADSET_KEY;
    rdata_next = reg_rd_i ? rd_mux : rdata_reg;
    alt_next = open_ev_next | meas_ev_next;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rise_en_reg <= 1'b0;
      fall_en_reg <= 1'b0;
      ck_meas_ie_reg <= 1'b0;
      vm_meas_ie_reg <= 1'b0;
      vm_rsvd_reg <= 1'b0;
      start_reg <= 1'b0;
      start_pulse_reg <= 1'b0;
      done_reg <= 1'b0;
      code_reg <= CODE_RESET;
      float_q_reg <= 1'b0;
      open_ev_reg <= 1'b0;
      meas_ev_reg <= 1'b0;
      boost_reg <= BOOST_RESET;
      key_reg <= HEADSET_RESET;
      rdata_reg <= 8'h00;
      audio_reg <= 1'b0;
      alt_reg <= 1'b0;
    end else begin
      rise_en_reg <= rise_en_next;
      fall_en_reg <= fall_en_next;
      ck_meas_ie_reg <= ck_meas_ie_next;
      vm_meas_ie_reg <= vm_meas_ie_next;
      vm_rsvd_reg <= vm_rsvd_next;
      start_reg <= start_next;
      start_pulse_reg <= start_pulse_next;
      done_reg <= done_next;
      code_reg <= code_next;
      float_q_reg <= float_q_next;
      open_ev_reg <= open_ev_next;
      meas_ev_reg <= meas_ev_next;
      boost_reg <= boost_next;
      key_reg <= key_next;
      rdata_reg <= rdata_next;
      audio_reg <= audio_next;
      alt_reg <= alt_next;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign hs_boost_o = boost_reg;
  assign headset_audio_en_o = audio_reg;
  assign alt_int_o = alt_reg;
endmodule

// File: dv/ckv_link_model.sv
/*
  Link-side model: issues register reads and writes on the bank port.
  Assumes read data lands one cycle after the read strobe is taken.
*/
module ckv_link_model (
  input wire logic clk_i,            // System clock
  output logic [5:0] reg_addr_o,     // Register address
  output logic reg_wr_o,             // Write strobe
  output logic reg_rd_o,             // Read strobe
  output logic [7:0] reg_wdata_o,    // Write data
  input wire logic [7:0] reg_rdata_i // Read data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr_o = 6'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // Idle cycle after each strobe; released lines flip so stale values never match
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
  endtask
endmodule

// File: dv/ckv_monitor.sv
/*
  Checker for the carkit event and vendor register bank.
  Assumes it is bound to ckv_regs and sees only its ports.
*/
module ckv_monitor
  import ckv_pkg::*;
#(
  parameter int unsigned MEAS_CYCLES = MEASURE_CYCLES
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic id_float_i,
  input wire logic [2:0] id_code_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [1:0] hs_boost_o,
  input wire logic headset_audio_en_o,
  input wire logic alt_int_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_rd_st;
    reg_rd_i && reg_addr_i == ADDR_EVENT_STATUS;
  endsequence
  sequence s_rd_lt;
    reg_rd_i && reg_addr_i == ADDR_EVENT_LATCH;
  endsequence
  property p_st_rsvd;
    s_rd_st |=> reg_rdata_o[7] == 1'b0 && reg_rdata_o[2:1] == 2'h0;
  endproperty
  a_st_rsvd: assert property (p_st_rsvd) else $error("status spare bits set");
  property p_float_live;
    s_rd_st |=> reg_rdata_o[0] == $past(id_float_i);
  endproperty
  a_float_live: assert property (p_float_live) else $error("float bit wrong");
  property p_lt_rsvd;
    s_rd_lt |=> {reg_rdata_o[7:4], reg_rdata_o[2:1]} == 6'h00;
  endproperty
  a_lt_rsvd: assert property (p_lt_rsvd) else $error("latch spare bits set");
  property p_lt_alt;
    s_rd_lt |=> (reg_rdata_o[3] | reg_rdata_o[0]) == $past(alt_int_o);
  endproperty
  a_lt_alt: assert property (p_lt_alt) else $error("alt level disagrees");
  property p_boost_wr;
    reg_wr_i && reg_addr_i == ADDR_DRIVE_AMPL
      |=> {1'b0, hs_boost_o, 5'h00} == ($past(reg_wdata_i) & 8'h60);
  endproperty
  a_boost_wr: assert property (p_boost_wr) else $error("boost not taken");
  property p_boost_rd;
    reg_rd_i && reg_addr_i == ADDR_DRIVE_AMPL |=> reg_rdata_o == {1'b0, hs_boost_o, 5'h00};
  endproperty
  a_boost_rd: assert property (p_boost_rd) else $error("boost readback wrong");
  property p_key;
    reg_wr_i && reg_addr_i == ADDR_HEADSET_AUDIO
      |=> headset_audio_en_o == (($past(reg_wdata_i) & 8'h0f) == 8'h0a);
  endproperty
  a_key: assert property (p_key) else $error("headset enable wrong");
  property p_key_hold;
    !(reg_wr_i && reg_addr_i == ADDR_HEADSET_AUDIO) |=> $stable(headset_audio_en_o);
  endproperty
  a_key_hold: assert property (p_key_hold) else $error("headset moved");
  c_alt: cover property ($rose(alt_int_o));
  c_lt: cover property (s_rd_lt ##1 reg_rdata_o[3]);
  c_key: cover property ($rose(headset_audio_en_o));
endmodule
bind ckv_regs ckv_monitor #(.MEAS_CYCLES(MEAS_CYCLES)) mon_u (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_wdata_i(reg_wdata_i), .id_float_i(id_float_i), .id_code_i(id_code_i),
  .reg_rdata_o(reg_rdata_o), .hs_boost_o(hs_boost_o),
  .headset_audio_en_o(headset_audio_en_o), .alt_int_o(alt_int_o));

// File: dv/tb.sv
/*
  Testbench for the carkit event and vendor register bank.
  Assumes the link model for bus cycles and a shortened conversion.
*/
module tb
  import ckv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MC = 20;
  logic clk_i, sys_rst_i, wr, rd, id_float_i, hs_en, alt;
  logic [5:0] addr;
  logic [7:0] wdata, rdata;
  logic [2:0] id_code_i;
  logic [1:0] boost;
  int num_errors = 0;
  int checked = 0;
  logic [5:0] zr[6] = '{ADDR_EVENT_STATUS, ADDR_EVENT_LATCH, ADDR_DRIVE_AMPL,
    ADDR_HEADSET_AUDIO, ADDR_ID_MEASURE_WR, 6'h3f};
  logic [3:0] hk[4] = '{4'ha, 4'h5, 4'hb, 4'ha};
  ckv_regs #(.MEAS_CYCLES(MC)) dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .id_float_i(id_float_i), .id_code_i(id_code_i), .reg_rdata_o(rdata),
    .hs_boost_o(boost), .headset_audio_en_o(hs_en), .alt_int_o(alt));
  ckv_link_model link_u (.clk_i(clk_i), .reg_addr_o(addr), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_wdata_o(wdata), .reg_rdata_i(rdata));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    link_u.rd(a, d);
    chk(d, e);
  endtask
  task automatic fl(input logic v, input logic [7:0] e);
    @(negedge clk_i);
    id_float_i = v;
    repeat (2) @(negedge clk_i);
    chk({7'h0, alt}, {7'h0, e[0]});
    rc(ADDR_EVENT_STATUS, {7'h0, v});
    rc(ADDR_EVENT_LATCH, e);
    rc(ADDR_EVENT_LATCH, 8'h00);
    chk({7'h0, alt}, 8'h00);
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    #50us;
    num_errors++;
    wrap_up();
  end
  initial begin
    sys_rst_i = 1'b1;
    id_float_i = 1'b0;
    id_code_i = 3'h0;
    repeat (12) @(negedge clk_i);
    sys_rst_i = 1'b0;
    foreach (zr[i]) rc(zr[i], 8'h00);
    for (int v = 0; v < 4; v++) begin
      link_u.wr(ADDR_DRIVE_AMPL, {1'b1, 2'(v), 5'h1f});
      rc(ADDR_DRIVE_AMPL, {1'b0, 2'(v), 5'h00});
      chk({6'h0, boost}, {6'h0, 2'(v)});
    end
    foreach (hk[i]) begin
      link_u.wr(ADDR_HEADSET_AUDIO, {4'hf, hk[i]});
      rc(ADDR_HEADSET_AUDIO, {4'h0, hk[i]});
      chk({7'h0, hs_en}, {7'h0, hk[i] == 4'ha});
    end
    link_u.wr(ADDR_EVENT_STATUS, 8'hff);
    link_u.wr(ADDR_EVENT_LATCH, 8'hff);
    rc(ADDR_EVENT_LATCH, 8'h00);
    rc(ADDR_EVENT_STATUS, 8'h00);
    link_u.wr(ADDR_CK_IRQ_EN_WR, 8'h01);
    fl(1'b1, 8'h01);
    fl(1'b0, 8'h00);
    link_u.wr(ADDR_CK_IRQ_EN_SET, 8'h02);
    rc(ADDR_CK_IRQ_EN_CLR, 8'h03);
    fl(1'b1, 8'h01);
    fl(1'b0, 8'h01);
    // Event lands on the very edge of the clearing read
    fork
      rc(ADDR_EVENT_LATCH, 8'h00);
      begin
        @(negedge clk_i);
        id_float_i = 1'b1;
      end
    join
    rc(ADDR_EVENT_LATCH, 8'h01);
    link_u.wr(ADDR_CK_IRQ_EN_CLR, 8'h01);
    fl(1'b0, 8'h01);
    fl(1'b1, 8'h00);
    link_u.wr(ADDR_CK_IRQ_EN_WR, 8'h00);
    fl(1'b0, 8'h00);
    id_code_i = 3'h5;
    link_u.wr(ADDR_ID_MEASURE_WR, 8'h50);
    repeat (MC - 6) @(negedge clk_i);
    rc(ADDR_EVENT_STATUS, 8'h00);
    rc(ADDR_ID_MEASURE_SET, 8'h50);
    repeat (8) @(negedge clk_i);
    chk({7'h0, alt}, 8'h01);
    rc(ADDR_EVENT_STATUS, 8'h68);
    rc(ADDR_EVENT_STATUS, 8'h68);
    rc(ADDR_EVENT_LATCH, 8'h08);
    rc(ADDR_ID_MEASURE_CLR, 8'h4d);
    rc(ADDR_ID_MEASURE_WR, 8'h45);
    rc(ADDR_EVENT_STATUS, 8'h28);
    link_u.wr(ADDR_ID_MEASURE_CLR, 8'h40);
    rc(ADDR_ID_MEASURE_WR, 8'h05);
    link_u.wr(ADDR_CK_IRQ_EN_WR, 8'h20);
    id_code_i = 3'h7;
    link_u.wr(ADDR_ID_MEASURE_WR, 8'h10);
    repeat (MC + 6) @(negedge clk_i);
    rc(ADDR_EVENT_LATCH, 8'h08);
    rc(ADDR_ID_MEASURE_CLR, 8'h0f);
    link_u.wr(ADDR_CK_IRQ_EN_WR, 8'h00);
    link_u.wr(ADDR_ID_MEASURE_SET, 8'h10);
    repeat (MC + 6) @(negedge clk_i);
    rc(ADDR_EVENT_LATCH, 8'h00);
    rc(ADDR_ID_MEASURE_WR, 8'h0f);
    wrap_up();
  end
endmodule
